// ==== bench/scd_capture_props.sv ====
// Checker of the capture block ports
`timescale 1ns/1ns
module scd_capture_props
  import scd_pkg::*;
(
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  input wire logic                ig_valid,
  input wire logic                ig_eop,
  input wire logic                ig_sa_hit,
  input wire logic [SA_PTR_W-1:0] ig_sa_ptr,
  input wire logic                ig_fcs_replace,
  input wire logic [31:0]         ig_fcs_code,
  input wire logic                eg_valid,
  input wire logic                eg_eop,
  input wire logic                eg_fcs_replace,
  input wire logic [31:0]         eg_fcs_code
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_ig_end; ig_valid && ig_eop; endsequence
  sequence s_eg_end; eg_valid && eg_eop; endsequence
  sequence s_ig_hit; ig_valid && ig_eop && ig_sa_hit; endsequence
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero");
  AST_IG_FAIL_BIT: assert property (s_ig_end |=> ig_fcs_code[31])
    else $error("ingress code bit 31 low");
  AST_EG_FAIL_BIT: assert property (s_eg_end |=> eg_fcs_code[31])
    else $error("egress code bit 31 low");
  AST_IG_REPL_CAUSE: assert property (!(ig_valid && ig_eop) |=> !ig_fcs_replace)
    else $error("ingress replace without frame end");
  AST_EG_REPL_CAUSE: assert property (!(eg_valid && eg_eop) |=> !eg_fcs_replace)
    else $error("egress replace without frame end");
  AST_IG_HOLD: assert property (!(ig_valid && ig_eop) |=> $stable(ig_fcs_code))
    else $error("ingress code changed");
  AST_IG_PTR: assert property (s_ig_hit |=> ig_fcs_code[30] && ig_fcs_code[29:24] == $past(ig_sa_ptr))
    else $error("ingress pointer field wrong");
  AST_IG_NOHIT: assert property (s_ig_end ##0 !ig_sa_hit |=> ig_fcs_code[30:27] == 4'h0)
    else $error("ingress reserved field set");
  AST_EG_ZERO: assert property (s_eg_end |=> eg_fcs_code[23:19] == 5'h0 && eg_fcs_code[9:6] == 4'h0)
    else $error("egress upper events set");
endmodule // scd_capture_props

// ==== bench/scd_frame_src.sv ====
// Frame source standing in for one datapath direction
`timescale 1ns/1ns
module scd_frame_src
  import scd_pkg::*;
#(
  parameter int unsigned GW = IG_GLOBAL_W,
  parameter int unsigned SW = IG_SA_W
) (
  input  wire logic           clk_sys,
  output logic                valid,
  output logic                sop,
  output logic                eop,
  output logic [31:0]         data,
  output logic [1:0]          last_bytes,
  output logic [GW-1:0]       gvec,
  output logic [SW-1:0]       svec,
  output logic                hit,
  output logic [SA_PTR_W-1:0] ptr,
  output logic [3:0]          cls
);
  initial begin
    {valid, sop, eop, data, last_bytes, gvec, svec, hit, ptr, cls} = '0;
  end
  task automatic send(input int n, input logic [1:0] lb, input logic [GW-1:0] g, input logic [SW-1:0] s,
                      input logic h, input logic [SA_PTR_W-1:0] p, input logic [3:0] c);
    for (int i = 0; i < n; i++) begin
      valid <= 1'b1;
      sop   <= (i == 0);
      eop   <= (i == n - 1);
      data  <= 32'hA5000000 + 32'(i);
      {last_bytes, gvec, svec, hit, ptr, cls} <= {lb, g, s, h, p, c};
      @(posedge clk_sys);
    end
    {valid, sop, eop} <= 3'h0;
    data <= ~data;
    {last_bytes, gvec, svec, hit, ptr, cls} <= ~{lb, g, s, h, p, c};
    @(posedge clk_sys);
  endtask
endmodule // scd_frame_src

// ==== bench/test_secfail_debug_capture.sv ====
// Testbench of the security-fail debug capture block
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_secfail_debug_capture
  import scd_pkg::*;
;
  logic                   clk_sys, rst_n, reg_wr, reg_rd, dbg, h;
  logic [7:0]             reg_addr;
  logic [31:0]            reg_wdata, reg_rdata, ig_fcs_code, eg_fcs_code, ig_data, eg_data;
  logic                   ig_valid, ig_sop, ig_eop, ig_sa_hit, ig_fcs_replace;
  logic                   eg_valid, eg_sop, eg_eop, eg_sa_hit, eg_fcs_replace;
  logic [1:0]             ig_lb, eg_lb;
  logic [IG_GLOBAL_W-1:0] ig_gv, g, gm;
  logic [IG_SA_W-1:0]     ig_sv, s, sm;
  logic [EG_GLOBAL_W-1:0] eg_gv;
  logic [EG_SA_W-1:0]     eg_sv;
  logic [5:0]             ig_ptr, eg_ptr, p;
  logic [3:0]             ig_cls, eg_cls, c;
  logic [31:0]            exp_w [8];
  int                     err_count, check_count, seed, rep_cnt, exp_rep;

  scd_capture scd_capture_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ig_valid(ig_valid), .ig_sop(ig_sop),
    .ig_eop(ig_eop), .ig_data(ig_data), .ig_last_bytes(ig_lb), .ig_global_vec(ig_gv), .ig_sa_vec(ig_sv),
    .ig_sa_hit(ig_sa_hit), .ig_sa_ptr(ig_ptr), .ig_is_ctrl(ig_cls[3]), .ig_tag_present(ig_cls[2]),
    .ig_tag_bad(ig_cls[1]), .ig_tag_key_agree(ig_cls[0]), .ig_fcs_replace(ig_fcs_replace),
    .ig_fcs_code(ig_fcs_code), .eg_valid(eg_valid), .eg_sop(eg_sop), .eg_eop(eg_eop), .eg_data(eg_data),
    .eg_last_bytes(eg_lb), .eg_global_vec(eg_gv), .eg_sa_vec(eg_sv), .eg_sa_hit(eg_sa_hit),
    .eg_sa_ptr(eg_ptr), .eg_is_ctrl(eg_cls[3]), .eg_tag_present(eg_cls[2]), .eg_tag_bad(eg_cls[1]),
    .eg_tag_key_agree(eg_cls[0]), .eg_fcs_replace(eg_fcs_replace), .eg_fcs_code(eg_fcs_code));
  scd_frame_src #(.GW(IG_GLOBAL_W), .SW(IG_SA_W)) src_ig_i (.clk_sys(clk_sys), .valid(ig_valid),
    .sop(ig_sop), .eop(ig_eop), .data(ig_data), .last_bytes(ig_lb), .gvec(ig_gv), .svec(ig_sv),
    .hit(ig_sa_hit), .ptr(ig_ptr), .cls(ig_cls));
  scd_frame_src #(.GW(EG_GLOBAL_W), .SW(EG_SA_W)) src_eg_i (.clk_sys(clk_sys), .valid(eg_valid),
    .sop(eg_sop), .eop(eg_eop), .data(eg_data), .last_bytes(eg_lb), .gvec(eg_gv), .svec(eg_sv),
    .hit(eg_sa_hit), .ptr(eg_ptr), .cls(eg_cls));

  function automatic logic [31:0] fcode(input logic hh, input logic [5:0] pp, input logic [3:0] cc,
                                        input logic [13:0] gg, input logic [9:0] ss);
    logic [1:0] t;
    t = cc[0] ? TAG_KEY_AGREE : cc[1] ? TAG_BAD : cc[2] ? TAG_TAGGED : TAG_UNTAGGED;
    fcode = {1'b1, hh, hh ? pp : {3'h0, cc[3], t}, gg, ss};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge clk_sys);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    rep_cnt <= rep_cnt + int'(ig_fcs_replace | eg_fcs_replace);
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {err_count, check_count, exp_rep} = '0;
    seed = 32'ha694;
    rst_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(OFF_CONTROL, 32'h000001F8);
    rd(OFF_STATE, 32'h00000000);
    rd(OFF_SA_MASK_LO, 32'h00000000);
    rd(8'h85, 32'h00000000);
    $display("test 1 done");
    for (int k = 0; k < 24; k++) begin
      dbg = 1'($random(seed));
      gm  = 18'($random(seed));
      sm  = 13'($random(seed));
      g   = 18'($random(seed));
      s   = 13'($random(seed));
      h   = 1'($random(seed));
      p   = 6'($random(seed));
      c   = 4'($random(seed));
      wr(OFF_GLOBAL_MASK, 32'(gm));
      wr(OFF_PER_SA_MASK, 32'(sm));
      wr(OFF_CONTROL, {7'h0, dbg, 7'h0, 1'b1, 7'h0, 9'h1F8});
      if (k[0]) begin
        src_ig_i.send(1, 2'h0, g, s, h, p, c);
        `CHK(ig_fcs_code, fcode(h, p, c, g[13:0], s[9:0]))
        exp_rep += int'(dbg & (|(g & gm) | |(s & sm)));
      end else begin
        src_eg_i.send(1, 2'h0, g[8:0], s[5:0], h, p, c);
        `CHK(eg_fcs_code, fcode(h, p, c, {5'h0, g[8:0]}, {4'h0, s[5:0]}))
        exp_rep += int'(dbg & (|(g[8:0] & gm[8:0]) | |(s[5:0] & sm[5:0])));
      end
    end
    repeat (2) @(posedge clk_sys);
    `CHK(rep_cnt, exp_rep)
    $display("test 2 done");
    wr(OFF_ARM, 32'h2);
    wr(OFF_GLOBAL_MASK, 32'h0);
    wr(OFF_PER_SA_MASK, 32'h0);
    wr(OFF_CONTROL, 32'h00010008);
    wr(OFF_SA_MASK_LO, 32'h3);
    wr(OFF_ARM, 32'h1);
    src_ig_i.send(3, 2'h0, 18'h0, 13'h0, 1'b1, 6'h0, 4'h0);
    src_ig_i.send(1, 2'h0, 18'h0, 13'h0, 1'b1, 6'h0, 4'h0);
    src_eg_i.send(1, 2'h0, 9'h0, 6'h0, 1'b1, 6'h1, 4'h0);
    wr(OFF_GLOBAL_MASK, 32'h1);
    src_ig_i.send(2, 2'h2, 18'h1, 13'h0, 1'b0, 6'h0, 4'h5);
    rd(OFF_STATE, 32'h00080002);
    rd(OFF_SA_MASK_LO, 32'h00000002);
    rd(8'h80, 32'h00000000);
    wr(OFF_ARM, 32'h0);
    exp_w = '{32'h00000208, fcode(1'b1, 6'h0, 4'h0, 14'h0, 10'h0), 32'hA5000000, 32'hA5000001,
              32'h00000006, fcode(1'b0, 6'h0, 4'h5, 14'h1, 10'h0), 32'hA5000000, 32'hA5000001};
    for (int i = 0; i < 8; i++) begin
      rd(8'h80 + 8'(i), exp_w[i]);
    end
    $display("test 3 done");
    wr(OFF_ARM, 32'h2);
    wr(OFF_CONTROL, 32'h000101F8);
    wr(OFF_ARM, 32'h1);
    repeat (4) src_ig_i.send(40, 2'h0, 18'h1, 13'h0, 1'b0, 6'h0, 4'h0);
    rd(OFF_STATE, 32'h007E0103);
    wr(OFF_ARM, 32'h2);
    wr(OFF_ARM, 32'h1);
    src_ig_i.send(130, 2'h0, 18'h1, 13'h0, 1'b0, 6'h0, 4'h0);
    wr(OFF_ARM, 32'h0);
    rd(8'h80, 32'h000003F8);
    $display("test 4 done");
    wr(OFF_ARM, 32'h2);
    wr(OFF_CONTROL, 32'h000001F8);
    wr(OFF_ARM, 32'h1);
    src_ig_i.send(1, 2'h0, 18'h1, 13'h0, 1'b0, 6'h0, 4'h0);
    src_eg_i.send(1, 2'h3, 9'h1, 6'h0, 1'b0, 6'h0, 4'h0);
    rd(OFF_STATE, 32'h00030001);
    wr(OFF_ARM, 32'h0);
    rd(8'h80, 32'h00000003);
    rd(8'h81, fcode(1'b0, 6'h0, 4'h0, 14'h1, 10'h0));
    rd(8'h82, 32'hA5000000);
    $display("test 5 done");
    stop_test();
  end
endmodule // test_secfail_debug_capture

bind scd_capture scd_capture_props scd_capture_props_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ig_valid(ig_valid), .ig_eop(ig_eop), .ig_sa_hit(ig_sa_hit), .ig_sa_ptr(ig_sa_ptr),
  .ig_fcs_replace(ig_fcs_replace), .ig_fcs_code(ig_fcs_code), .eg_valid(eg_valid), .eg_eop(eg_eop),
  .eg_fcs_replace(eg_fcs_replace), .eg_fcs_code(eg_fcs_code));

// ==== src/scd_capture.sv ====
// Security-fail debug: FCS fault code and capture FIFO
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module scd_capture
  import scd_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]      reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  // Ingress stream after transformation
  input  wire logic                   ig_valid,
  input  wire logic                   ig_sop,
  input  wire logic                   ig_eop,
  input  wire logic [31:0]            ig_data,
  input  wire logic [1:0]             ig_last_bytes,
  input  wire logic [IG_GLOBAL_W-1:0] ig_global_vec,
  input  wire logic [IG_SA_W-1:0]     ig_sa_vec,
  input  wire logic                   ig_sa_hit,
  input  wire logic [SA_PTR_W-1:0]    ig_sa_ptr,
  input  wire logic                   ig_is_ctrl,
  input  wire logic                   ig_tag_present,
  input  wire logic                   ig_tag_bad,
  input  wire logic                   ig_tag_key_agree,
  output logic                        ig_fcs_replace,
  output logic [31:0]                 ig_fcs_code,
  // Egress stream after transformation
  input  wire logic                   eg_valid,
  input  wire logic                   eg_sop,
  input  wire logic                   eg_eop,
  input  wire logic [31:0]            eg_data,
  input  wire logic [1:0]             eg_last_bytes,
  input  wire logic [EG_GLOBAL_W-1:0] eg_global_vec,
  input  wire logic [EG_SA_W-1:0]     eg_sa_vec,
  input  wire logic                   eg_sa_hit,
  input  wire logic [SA_PTR_W-1:0]    eg_sa_ptr,
  input  wire logic                   eg_is_ctrl,
  input  wire logic                   eg_tag_present,
  input  wire logic                   eg_tag_bad,
  input  wire logic                   eg_tag_key_agree,
  output logic                        eg_fcs_replace,
  output logic [31:0]                 eg_fcs_code
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    scd_st_t                     st;
    logic [FIFO_DEPTH-1:0][31:0] mem;
    logic [7:0]                  wr_idx;
    logic [7:0]                  cur_idx;
    logic [SIZE_W-1:0]           bytes;
    logic                        trunc;
    logic [7:0]                  pkt_cnt;
    logic                        full;
    logic [SIZE_W-1:0]           max_size;
    logic                        side;
    logic                        dbg_en;
    logic                        cap_en;
    logic [63:0]                 sa_mask;
    logic [IG_GLOBAL_W-1:0]      gmask;
    logic [IG_SA_W-1:0]          smask;
    logic [31:0]                 rdata;
    logic                        ig_rep;
    logic [31:0]                 ig_code;
    logic                        eg_rep;
    logic [31:0]                 eg_code;
  } scd_state_t;

  scd_state_t s_q;
  scd_state_t s_d;

  // ----------------------------------------------------------------
  // Fault code per direction
  // ----------------------------------------------------------------
  logic        ig_fail;
  logic [31:0] ig_code;
  logic        eg_fail;
  logic [31:0] eg_code;

  scd_fault_code #(
    .GW (IG_GLOBAL_W),
    .SW (IG_SA_W)
  ) u_ig_code (
    .global_vec             (ig_global_vec),
    .sa_vec                 (ig_sa_vec),
    .global_fail_event_mask (s_q.gmask),
    .per_sa_fail_event_mask (s_q.smask),
    .sa_hit                 (ig_sa_hit),
    .sa_ptr                 (ig_sa_ptr),
    .is_ctrl                (ig_is_ctrl),
    .tag_present            (ig_tag_present),
    .tag_bad                (ig_tag_bad),
    .tag_key_agree          (ig_tag_key_agree),
    .fail                   (ig_fail),
    .code                   (ig_code)
  );

  scd_fault_code #(
    .GW (EG_GLOBAL_W),
    .SW (EG_SA_W)
  ) u_eg_code (
    .global_vec             (eg_global_vec),
    .sa_vec                 (eg_sa_vec),
    .global_fail_event_mask (s_q.gmask),
    .per_sa_fail_event_mask (s_q.smask),
    .sa_hit                 (eg_sa_hit),
    .sa_ptr                 (eg_sa_ptr),
    .is_ctrl                (eg_is_ctrl),
    .tag_present            (eg_tag_present),
    .tag_bad                (eg_tag_bad),
    .tag_key_agree          (eg_tag_key_agree),
    .fail                   (eg_fail),
    .code                   (eg_code)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic                  c_valid;
  logic                  c_sop;
  logic                  c_eop;
  logic [31:0]           c_data;
  logic [1:0]            c_last;
  logic                  c_fail;
  logic [31:0]           c_code;
  logic                  c_hit;
  logic [63:0]           c_sel;
  logic                  go;
  logic [7:0]            cur;
  logic [SIZE_W-1:0]     bc;
  logic                  tr;
  logic [2:0]            nb;
  logic [SIZE_W-1:0]     limit;
  logic [31:0]           hdr0;
  logic                  full_set;

  always_comb begin
    s_d = s_q;
    s_d.ig_rep = 1'b0;
    s_d.eg_rep = 1'b0;
    s_d.rdata = 32'h0;
    go = 1'b0;
    cur = s_q.cur_idx;
    bc = s_q.bytes;
    tr = s_q.trunc;
    hdr0 = 32'h0;
    full_set = 1'b0;

    if (ig_valid && ig_eop) begin
      s_d.ig_rep = s_q.dbg_en & ig_fail;
      s_d.ig_code = ig_code;
    end
    if (eg_valid && eg_eop) begin
      s_d.eg_rep = s_q.dbg_en & eg_fail;
      s_d.eg_code = eg_code;
    end

    c_valid = s_q.side ? ig_valid : eg_valid;
    c_sop   = s_q.side ? ig_sop : eg_sop;
    c_eop   = s_q.side ? ig_eop : eg_eop;
    c_data  = s_q.side ? ig_data : eg_data;
    c_last  = s_q.side ? ig_last_bytes : eg_last_bytes;
    c_fail  = s_q.side ? ig_fail : eg_fail;
    c_code  = s_q.side ? ig_code : eg_code;
    c_hit   = s_q.side ? ig_sa_hit : eg_sa_hit;
    c_sel   = scd_sa_onehot(s_q.side ? ig_sa_ptr : eg_sa_ptr);

    limit = (s_q.max_size > CAPT_LIMIT) ? CAPT_LIMIT : s_q.max_size;
    nb = (c_eop && (c_last != 2'h0)) ? {1'b0, c_last} : WORD_BYTES;

    unique case (s_q.st)
      ST_IDLE: begin
        if (s_q.cap_en && c_valid && c_sop) begin
          if ((s_q.wr_idx + HDR_WORDS) < FIFO_END) begin
            go = 1'b1;
            cur = s_q.wr_idx + HDR_WORDS;
            bc = '0;
            tr = 1'b0;
          end else begin
            s_d.full = 1'b1;
            full_set = 1'b1;
            if (!c_eop) begin
              s_d.st = ST_SKIP;
            end
          end
        end
      end
      ST_CAPT: begin
        if (!s_q.cap_en) begin
          s_d.st = ST_IDLE;
        end else if (c_valid) begin
          go = 1'b1;
        end
      end
      ST_SKIP: begin
        if ((c_valid && c_eop) || !s_q.cap_en) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    if (go) begin
      if (bc >= limit) begin
        tr = 1'b1;
      end else if (cur >= FIFO_END) begin
        tr = 1'b1;
        s_d.full = 1'b1;
        full_set = 1'b1;
      end else begin
        s_d.mem[cur[6:0]] = c_data;
        cur = cur + 8'h01;
        if (({1'b0, bc} + 10'(nb)) > {1'b0, limit}) begin
          bc = limit;
          tr = 1'b1;
        end else begin
          bc = bc + SIZE_W'(nb);
        end
      end
      if (c_eop) begin
        s_d.st = ST_IDLE;
        if (c_fail || (c_hit && |(s_q.sa_mask & c_sel))) begin
          hdr0[HDR_TRUNC_BIT] = tr;
          hdr0[SIZE_W-1:0] = bc;
          s_d.mem[s_q.wr_idx[6:0]] = hdr0;
          s_d.mem[s_q.wr_idx[6:0] + 7'h01] = c_code;
          s_d.wr_idx = cur;
          s_d.pkt_cnt = s_q.pkt_cnt + 8'h01;
          if (c_hit) begin
            s_d.sa_mask = s_q.sa_mask & ~c_sel;
          end
        end
      end else begin
        s_d.st = ST_CAPT;
      end
      s_d.cur_idx = cur;
      s_d.bytes = bc;
      s_d.trunc = tr;
    end

    // Software writes
    if (reg_wr) begin
      unique case (reg_addr)
        OFF_CONTROL: begin
          s_d.max_size = reg_wdata[SIZE_W-1:0];
          s_d.side = reg_wdata[CTRL_SIDE_BIT];
          s_d.dbg_en = reg_wdata[CTRL_DEBUG_BIT];
        end
        OFF_ARM: begin
          s_d.cap_en = reg_wdata[ARM_ENABLE_BIT];
          if (reg_wdata[ARM_CLEAR_BIT]) begin
            s_d.wr_idx = 8'h00;
            s_d.pkt_cnt = 8'h00;
            // Full set wins over clear
            s_d.full = full_set;
            s_d.st = ST_IDLE;
          end
        end
        OFF_SA_MASK_LO: s_d.sa_mask[31:0] = reg_wdata;
        OFF_SA_MASK_HI: s_d.sa_mask[63:32] = reg_wdata;
        OFF_GLOBAL_MASK: s_d.gmask = reg_wdata[IG_GLOBAL_W-1:0];
        OFF_PER_SA_MASK: s_d.smask = reg_wdata[IG_SA_W-1:0];
        default: begin
        end
      endcase
    end

    // Software reads
    if (reg_rd) begin
      if (reg_addr[WINDOW_SEL_BIT]) begin
        s_d.rdata = s_q.cap_en ? 32'h0 : s_q.mem[reg_addr[6:0]];
      end else begin
        unique case (reg_addr)
          OFF_CONTROL: begin
            s_d.rdata[SIZE_W-1:0] = s_q.max_size;
            s_d.rdata[CTRL_SIDE_BIT] = s_q.side;
            s_d.rdata[CTRL_DEBUG_BIT] = s_q.dbg_en;
          end
          OFF_ARM: s_d.rdata[ARM_ENABLE_BIT] = s_q.cap_en;
          OFF_STATE: begin
            s_d.rdata[7:0] = s_q.pkt_cnt;
            s_d.rdata[STATE_FULL_BIT] = s_q.full;
            s_d.rdata[STATE_IDX_LSB +: 8] = s_q.wr_idx;
          end
          OFF_SA_MASK_LO: s_d.rdata = s_q.sa_mask[31:0];
          OFF_SA_MASK_HI: s_d.rdata = s_q.sa_mask[63:32];
          OFF_GLOBAL_MASK: s_d.rdata[IG_GLOBAL_W-1:0] = s_q.gmask;
          OFF_PER_SA_MASK: s_d.rdata[IG_SA_W-1:0] = s_q.smask;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.max_size <= MAX_SIZE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata      = s_q.rdata;
  assign ig_fcs_replace = s_q.ig_rep;
  assign ig_fcs_code    = s_q.ig_code;
  assign eg_fcs_replace = s_q.eg_rep;
  assign eg_fcs_code    = s_q.eg_code;

endmodule // scd_capture

// ==== src/scd_fault_code.sv ====
// Security-fail decision and 32-bit fault code for one direction
`timescale 1ns/1ns
module scd_fault_code
  import scd_pkg::*;
#(
  parameter int unsigned GW = IG_GLOBAL_W,
  parameter int unsigned SW = IG_SA_W
) (
  input  wire logic [GW-1:0]          global_vec,
  input  wire logic [SW-1:0]          sa_vec,
  input  wire logic [IG_GLOBAL_W-1:0] global_fail_event_mask,
  input  wire logic [IG_SA_W-1:0]     per_sa_fail_event_mask,
  input  wire logic                   sa_hit,
  input  wire logic [SA_PTR_W-1:0]    sa_ptr,
  input  wire logic                   is_ctrl,
  input  wire logic                   tag_present,
  input  wire logic                   tag_bad,
  input  wire logic                   tag_key_agree,
  output logic                        fail,
  output logic [31:0]                 code
);

  logic [IG_GLOBAL_W-1:0] gfull;
  logic [IG_SA_W-1:0]     sfull;
  logic [1:0]             tag;

  always_comb begin
    // Unused upper positions read as zero
    gfull = IG_GLOBAL_W'(global_vec);
    sfull = IG_SA_W'(sa_vec);
    fail = (|(gfull & global_fail_event_mask)) | (|(sfull & per_sa_fail_event_mask));
    if (tag_key_agree) begin
      tag = TAG_KEY_AGREE;
    end else if (tag_bad) begin
      tag = TAG_BAD;
    end else if (tag_present) begin
      tag = TAG_TAGGED;
    end else begin
      tag = TAG_UNTAGGED;
    end
    code = 32'h0;
    code[FC_FAIL_BIT] = 1'b1;
    code[FC_HIT_BIT] = sa_hit;
    code[FC_GLOBAL_LSB +: FC_GLOBAL_W] = gfull[FC_GLOBAL_W-1:0];
    code[FC_SA_LSB +: FC_SA_W] = sfull[FC_SA_W-1:0];
    if (sa_hit) begin
      code[FC_PTR_LSB +: SA_PTR_W] = sa_ptr;
    end else begin
      code[FC_CTRL_BIT] = is_ctrl;
      code[FC_TAG_LSB +: 2] = tag;
    end
  end

endmodule // scd_fault_code

// ==== src/scd_pkg.sv ====
// Constants and helpers for the security-fail debug capture block
package scd_pkg;

  // ----------------------------------------------------------------
  // Register offsets (word index on the register port)
  // ----------------------------------------------------------------
  localparam int unsigned     ADDR_W          = 8;
  localparam logic [7:0]      OFF_CONTROL     = 8'h00;
  localparam logic [7:0]      OFF_ARM         = 8'h01;
  localparam logic [7:0]      OFF_STATE       = 8'h02;
  localparam logic [7:0]      OFF_SA_MASK_LO  = 8'h03;
  localparam logic [7:0]      OFF_SA_MASK_HI  = 8'h04;
  localparam logic [7:0]      OFF_GLOBAL_MASK = 8'h05;
  localparam logic [7:0]      OFF_PER_SA_MASK = 8'h06;
  localparam int unsigned     WINDOW_SEL_BIT  = 7;

  // ----------------------------------------------------------------
  // Register fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned     SIZE_W          = 9;
  localparam int unsigned     CTRL_SIDE_BIT   = 16;
  localparam int unsigned     CTRL_DEBUG_BIT  = 24;
  localparam int unsigned     ARM_ENABLE_BIT  = 0;
  localparam int unsigned     ARM_CLEAR_BIT   = 1;
  localparam int unsigned     STATE_FULL_BIT  = 8;
  localparam int unsigned     STATE_IDX_LSB   = 16;
  localparam logic [8:0]      MAX_SIZE_RST    = 9'h1F8;

  // ----------------------------------------------------------------
  // Capture FIFO geometry and header layout
  // ----------------------------------------------------------------
  localparam int unsigned     FIFO_DEPTH      = 128;
  localparam logic [7:0]      FIFO_END        = 8'h80;
  localparam logic [7:0]      HDR_WORDS       = 8'h02;
  localparam logic [8:0]      CAPT_LIMIT      = 9'h1F8;
  localparam logic [2:0]      WORD_BYTES      = 3'h4;
  localparam int unsigned     HDR_TRUNC_BIT   = 9;

  // ----------------------------------------------------------------
  // Fault code layout and event vector widths
  // ----------------------------------------------------------------
  localparam int unsigned     FC_FAIL_BIT     = 31;
  localparam int unsigned     FC_HIT_BIT      = 30;
  localparam int unsigned     FC_PTR_LSB      = 24;
  localparam int unsigned     FC_CTRL_BIT     = 26;
  localparam int unsigned     FC_TAG_LSB      = 24;
  localparam int unsigned     FC_GLOBAL_LSB   = 10;
  localparam int unsigned     FC_GLOBAL_W     = 14;
  localparam int unsigned     FC_SA_LSB       = 0;
  localparam int unsigned     FC_SA_W         = 10;
  localparam int unsigned     SA_PTR_W        = 6;
  localparam int unsigned     IG_GLOBAL_W     = 18;
  localparam int unsigned     IG_SA_W         = 13;
  localparam int unsigned     EG_GLOBAL_W     = 9;
  localparam int unsigned     EG_SA_W         = 6;

  // Tag classification codes
  localparam logic [1:0]      TAG_UNTAGGED    = 2'h0;
  localparam logic [1:0]      TAG_TAGGED      = 2'h1;
  localparam logic [1:0]      TAG_BAD         = 2'h2;
  localparam logic [1:0]      TAG_KEY_AGREE   = 2'h3;

  // Capture states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CAPT = 3'h2,
    ST_SKIP = 3'h4
  } scd_st_t;

  // One-hot select of an SA in the 64-bit first-packet mask
  function automatic logic [63:0] scd_sa_onehot(input logic [SA_PTR_W-1:0] ptr);
    scd_sa_onehot = 64'h1 << ptr;
  endfunction

endpackage
